// ===== smsc_strobe_ctrl.sv
// Static memory strobe engine: chip select, read and write strobe waveforms
module smsc_strobe_ctrl #(
    parameter int NUM_CS = 4
) (
    // Clock and reset
    input  wire logic                                         clk_in,
    input  wire logic                                         reset_in,
    // Access request
    input  wire logic                                         req_valid_in,
    output logic                                              req_ready_out,
    input  wire logic                                         req_write_in,
    input  wire logic [((NUM_CS > 1) ? $clog2(NUM_CS) : 1)-1:0] req_cs_in,
    input  wire logic [smsc_pkg::ADDR_W-1:0]                  req_addr_in,
    input  wire logic [smsc_pkg::DATA_W-1:0]                  req_wdata_in,
    input  wire logic [1:0]                                   req_byte_en_in,
    // Read answer
    output logic [smsc_pkg::DATA_W-1:0]                       rdata_out,
    output logic                                              rdata_valid_out,
    // Per chip select timing
    input  wire logic [NUM_CS-1:0][smsc_pkg::SETUP_W-1:0]     rd_strobe_setup_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::PULSE_W-1:0]     rd_strobe_pulse_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::SETUP_W-1:0]     cs_read_setup_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::PULSE_W-1:0]     cs_read_pulse_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::CYCLE_W-1:0]     read_cycle_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::SETUP_W-1:0]     wr_strobe_setup_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::PULSE_W-1:0]     wr_strobe_pulse_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::SETUP_W-1:0]     cs_write_setup_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::PULSE_W-1:0]     cs_write_pulse_cnt_in,
    input  wire logic [NUM_CS-1:0][smsc_pkg::CYCLE_W-1:0]     write_cycle_cnt_in,
    // Per chip select mode
    input  wire logic [NUM_CS-1:0]                            read_mode_in,
    input  wire logic [NUM_CS-1:0]                            write_mode_in,
    input  wire logic [NUM_CS-1:0]                            byte_write_mode_in,
    input  wire logic [NUM_CS-1:0]                            matrix_flash_cs_config_in,
    // Memory pins
    output logic [smsc_pkg::ADDR_W-1:0]                       addr_out,
    output logic [NUM_CS-1:0]                                 chip_select_n_out,
    output logic                                              read_strobe_n_out,
    output logic                                              write_strobe_n_out,
    output logic                                              byte1_write_strobe_n_out,
    output logic                                              byte0_select_n_out,
    output logic                                              byte1_select_n_out,
    output logic [smsc_pkg::DATA_W-1:0]                       data_out,
    output logic                                              data_oe_n_out,
    input  wire logic [smsc_pkg::DATA_W-1:0]                  data_in,
    // Flash pins
    output logic                                              flash_output_enable_n_out,
    output logic                                              flash_write_enable_n_out,
    output logic                                              flash_chip_enable_n_out,
    output logic                                              flash_ale_out,
    output logic                                              flash_cle_out
);

    localparam int CS_W = (NUM_CS > 1) ? $clog2(NUM_CS) : 1;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NUM_CS < 1 || NUM_CS > smsc_pkg::NUM_CS_MAX) begin : g_bad_cs
        $error("NUM_CS must lie between 1 and 4");
    end

    // ------------------------------------------------------------
    // Phase helpers
    // ------------------------------------------------------------
    // Low phase spans setup <= cyc < setup + pulse
    function automatic logic phase_low(input logic [smsc_pkg::CYCLE_W-1:0] cyc,
                                       input logic [smsc_pkg::SETUP_W-1:0] s,
                                       input logic [smsc_pkg::PULSE_W-1:0] p);
        return (smsc_pkg::SUM_W'(cyc) >= smsc_pkg::SUM_W'(s)) &&
               (smsc_pkg::SUM_W'(cyc) < smsc_pkg::SUM_W'(s) + smsc_pkg::SUM_W'(p));
    endfunction : phase_low

    // True in the last low cycle, so the coming edge raises the strobe
    function automatic logic pulse_end(input logic [smsc_pkg::CYCLE_W-1:0] cyc,
                                       input logic [smsc_pkg::SETUP_W-1:0] s,
                                       input logic [smsc_pkg::PULSE_W-1:0] p);
        return (smsc_pkg::SUM_W'(cyc) + 11'h001) == (smsc_pkg::SUM_W'(s) + smsc_pkg::SUM_W'(p));
    endfunction : pulse_end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    smsc_pkg::smsc_state_t          state_ff, nxt_state;
    logic [smsc_pkg::CYCLE_W-1:0]   cyc_ff, nxt_cyc;
    logic                           wr_ff, nxt_wr;
    logic [CS_W-1:0]                cs_ff, nxt_cs;
    logic [1:0]                     be_ff, nxt_be;
    logic [smsc_pkg::SETUP_W-1:0]   ss_ff, nxt_ss;
    logic [smsc_pkg::PULSE_W-1:0]   sp_ff, nxt_sp;
    logic [smsc_pkg::SETUP_W-1:0]   css_ff, nxt_css;
    logic [smsc_pkg::PULSE_W-1:0]   csp_ff, nxt_csp;
    logic [smsc_pkg::CYCLE_W-1:0]   cycle_ff, nxt_cycle;
    logic                           mode_ff, nxt_mode;
    logic                           bwm_ff, nxt_bwm;
    logic                           flash_ff, nxt_flash;
    logic [smsc_pkg::ADDR_W-1:0]    addr_ff, nxt_addr;
    logic [smsc_pkg::DATA_W-1:0]    wdata_ff, nxt_wdata;
    logic [smsc_pkg::DATA_W-1:0]    rdata_ff, nxt_rdata;
    logic                           rvalid_ff, nxt_rvalid;
    logic [NUM_CS-1:0]              csn_ff, nxt_csn;
    logic                           rdn_ff, nxt_rdn;
    logic                           wen_ff, nxt_wen;
    logic                           we1n_ff, nxt_we1n;
    logic                           bs0n_ff, nxt_bs0n;
    logic                           bs1n_ff, nxt_bs1n;
    logic                           oen_ff, nxt_oen;
    logic                           foen_ff, nxt_foen;
    logic                           fwen_ff, nxt_fwen;
    logic                           fcen_ff, nxt_fcen;
    logic                           last, take, capture;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        logic act, rd_low, cs_low, wr_low;
        act    = 1'b0;
        rd_low = 1'b0;
        cs_low = 1'b0;
        wr_low = 1'b0;
        nxt_state = state_ff;
        nxt_cyc   = cyc_ff;
        nxt_wr    = wr_ff;
        nxt_cs    = cs_ff;
        nxt_be    = be_ff;
        nxt_ss    = ss_ff;
        nxt_sp    = sp_ff;
        nxt_css   = css_ff;
        nxt_csp   = csp_ff;
        nxt_cycle = cycle_ff;
        nxt_mode  = mode_ff;
        nxt_bwm   = bwm_ff;
        nxt_flash = flash_ff;
        nxt_addr  = addr_ff;
        nxt_wdata = wdata_ff;
        last = (smsc_pkg::SUM_W'(cyc_ff) + 11'h001) >= smsc_pkg::SUM_W'(cycle_ff);
        req_ready_out = (state_ff == smsc_pkg::SMSC_IDLE) || last;
        take = req_valid_in && req_ready_out;
        if (state_ff == smsc_pkg::SMSC_ACCESS) begin
            if (last) begin
                nxt_state = smsc_pkg::SMSC_IDLE;
            end else begin
                nxt_cyc = cyc_ff + 10'h001;
            end
        end
        if (take) begin
            nxt_state = smsc_pkg::SMSC_ACCESS;
            nxt_cyc   = smsc_pkg::CYC_RESET;
            nxt_wr    = req_write_in;
            nxt_cs    = req_cs_in;
            nxt_be    = req_byte_en_in;
            nxt_addr  = req_addr_in;
            nxt_wdata = req_wdata_in;
            nxt_bwm   = byte_write_mode_in[req_cs_in];
            nxt_flash = matrix_flash_cs_config_in[req_cs_in];
            if (req_write_in) begin
                nxt_ss    = wr_strobe_setup_cnt_in[req_cs_in];
                nxt_sp    = wr_strobe_pulse_cnt_in[req_cs_in];
                nxt_css   = cs_write_setup_cnt_in[req_cs_in];
                nxt_csp   = cs_write_pulse_cnt_in[req_cs_in];
                nxt_cycle = write_cycle_cnt_in[req_cs_in];
                nxt_mode  = write_mode_in[req_cs_in];
            end else begin
                nxt_ss    = rd_strobe_setup_cnt_in[req_cs_in];
                nxt_sp    = rd_strobe_pulse_cnt_in[req_cs_in];
                nxt_css   = cs_read_setup_cnt_in[req_cs_in];
                nxt_csp   = cs_read_pulse_cnt_in[req_cs_in];
                nxt_cycle = read_cycle_cnt_in[req_cs_in];
                nxt_mode  = read_mode_in[req_cs_in];
            end
        end
        // Outputs follow the cycle they will show; no compare of strobes
        act    = (nxt_state == smsc_pkg::SMSC_ACCESS);
        rd_low = act && !nxt_wr && phase_low(nxt_cyc, nxt_ss, nxt_sp);
        cs_low = act && phase_low(nxt_cyc, nxt_css, nxt_csp);
        wr_low = act && nxt_wr && phase_low(nxt_cyc, nxt_ss, nxt_sp);
        nxt_csn = '1;
        nxt_csn[nxt_cs] = !cs_low;
        nxt_rdn  = !rd_low;
        nxt_wen  = !(wr_low && (!nxt_bwm || nxt_be[0]));
        nxt_we1n = !(wr_low && nxt_bwm && nxt_be[1]);
        nxt_bs0n = !(act && !nxt_bwm && nxt_be[0]);
        nxt_bs1n = !(act && !nxt_bwm && nxt_be[1]);
        nxt_oen  = !(act && nxt_wr &&
                     (nxt_cyc >= smsc_pkg::CYCLE_W'(nxt_mode ? nxt_ss : nxt_css)));
        nxt_foen = !(rd_low && nxt_flash);
        nxt_fwen = !(wr_low && nxt_flash);
        nxt_fcen = !(cs_low && nxt_flash);
        capture = (state_ff == smsc_pkg::SMSC_ACCESS) && !wr_ff &&
                  (mode_ff ? pulse_end(cyc_ff, ss_ff, sp_ff)
                           : pulse_end(cyc_ff, css_ff, csp_ff));
        nxt_rvalid = capture;
        nxt_rdata  = capture ? data_in : rdata_ff;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_ff  <= smsc_pkg::SMSC_IDLE;
            cyc_ff    <= smsc_pkg::CYC_RESET;
            wr_ff     <= 1'b0;
            cs_ff     <= '0;
            be_ff     <= 2'h0;
            ss_ff     <= '0;
            sp_ff     <= '0;
            css_ff    <= '0;
            csp_ff    <= '0;
            cycle_ff  <= smsc_pkg::CYC_RESET;
            mode_ff   <= 1'b0;
            bwm_ff    <= 1'b0;
            flash_ff  <= 1'b0;
            addr_ff   <= smsc_pkg::ADDR_RESET;
            wdata_ff  <= smsc_pkg::DATA_RESET;
            rdata_ff  <= smsc_pkg::DATA_RESET;
            rvalid_ff <= 1'b0;
            csn_ff    <= '1;
            rdn_ff    <= smsc_pkg::STROBE_IDLE;
            wen_ff    <= smsc_pkg::STROBE_IDLE;
            we1n_ff   <= smsc_pkg::STROBE_IDLE;
            bs0n_ff   <= smsc_pkg::STROBE_IDLE;
            bs1n_ff   <= smsc_pkg::STROBE_IDLE;
            oen_ff    <= smsc_pkg::STROBE_IDLE;
            foen_ff   <= smsc_pkg::STROBE_IDLE;
            fwen_ff   <= smsc_pkg::STROBE_IDLE;
            fcen_ff   <= smsc_pkg::STROBE_IDLE;
        end else begin
            state_ff  <= nxt_state;
            cyc_ff    <= nxt_cyc;
            wr_ff     <= nxt_wr;
            cs_ff     <= nxt_cs;
            be_ff     <= nxt_be;
            ss_ff     <= nxt_ss;
            sp_ff     <= nxt_sp;
            css_ff    <= nxt_css;
            csp_ff    <= nxt_csp;
            cycle_ff  <= nxt_cycle;
            mode_ff   <= nxt_mode;
            bwm_ff    <= nxt_bwm;
            flash_ff  <= nxt_flash;
            addr_ff   <= nxt_addr;
            wdata_ff  <= nxt_wdata;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            csn_ff    <= nxt_csn;
            rdn_ff    <= nxt_rdn;
            wen_ff    <= nxt_wen;
            we1n_ff   <= nxt_we1n;
            bs0n_ff   <= nxt_bs0n;
            bs1n_ff   <= nxt_bs1n;
            oen_ff    <= nxt_oen;
            foen_ff   <= nxt_foen;
            fwen_ff   <= nxt_fwen;
            fcen_ff   <= nxt_fcen;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // address held from first cycle
    assign addr_out                  = addr_ff;
    assign chip_select_n_out         = csn_ff;
    assign read_strobe_n_out         = rdn_ff;
    assign write_strobe_n_out        = wen_ff;
    assign byte1_write_strobe_n_out  = we1n_ff;
    assign byte0_select_n_out        = bs0n_ff;
    assign byte1_select_n_out        = bs1n_ff;
    assign data_out                  = wdata_ff;
    assign data_oe_n_out             = oen_ff;
    assign rdata_out                 = rdata_ff;
    assign rdata_valid_out           = rvalid_ff;
    assign flash_output_enable_n_out = foen_ff;
    assign flash_write_enable_n_out  = fwen_ff;
    assign flash_chip_enable_n_out   = fcen_ff;
    // latch enables are plain address bits
    assign flash_ale_out             = addr_ff[smsc_pkg::ALE_BIT];
    assign flash_cle_out             = addr_ff[smsc_pkg::CLE_BIT];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    property p_idle_quiet;
        state_ff == smsc_pkg::SMSC_IDLE |-> (&csn_ff) && rdn_ff && wen_ff && we1n_ff
            && oen_ff && foen_ff && fwen_ff;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle pins active");
    property p_addr_first;
        take |=> addr_out == $past(req_addr_in) && cyc_ff == 10'h000
            && state_ff == smsc_pkg::SMSC_ACCESS;
    endproperty
    a_addr_first: assert property (p_addr_first) else $error("address not placed");
    property p_flash_copy;
        state_ff == smsc_pkg::SMSC_ACCESS && flash_ff |-> foen_ff == rdn_ff && fwen_ff == wen_ff;
    endproperty
    a_flash_copy: assert property (p_flash_copy) else $error("flash enable not copied");
    property p_flash_off;
        !flash_ff |-> foen_ff && fwen_ff && fcen_ff;
    endproperty
    a_flash_off: assert property (p_flash_off) else $error("flash enable outside space");
    property p_cap_rd;
        (state_ff == smsc_pkg::SMSC_ACCESS && !wr_ff && mode_ff && !rdn_ff) ##1 rdn_ff
            |-> rdata_valid_out && rdata_out == $past(data_in);
    endproperty
    a_cap_rd: assert property (p_cap_rd) else $error("no capture at read strobe rise");
    property p_cap_cs;
        (state_ff == smsc_pkg::SMSC_ACCESS && !wr_ff && !mode_ff && !csn_ff[cs_ff])
            ##1 csn_ff[$past(cs_ff)] |-> rdata_valid_out;
    endproperty
    a_cap_cs: assert property (p_cap_cs) else $error("no capture at select rise");
    property p_drive_wr;
        !oen_ff |-> state_ff == smsc_pkg::SMSC_ACCESS && wr_ff
            && cyc_ff >= smsc_pkg::CYCLE_W'(mode_ff ? ss_ff : css_ff);
    endproperty
    a_drive_wr: assert property (p_drive_wr) else $error("data driven out of phase");
    property p_rd_window;
        !rdn_ff |-> smsc_pkg::SUM_W'(cyc_ff) >= smsc_pkg::SUM_W'(ss_ff)
            && smsc_pkg::SUM_W'(cyc_ff) < smsc_pkg::SUM_W'(ss_ff) + smsc_pkg::SUM_W'(sp_ff);
    endproperty
    a_rd_window: assert property (p_rd_window) else $error("read strobe out of window");
    property p_wr_hold;
        state_ff == smsc_pkg::SMSC_ACCESS && wr_ff
            && smsc_pkg::SUM_W'(cyc_ff) >= smsc_pkg::SUM_W'(ss_ff) + smsc_pkg::SUM_W'(sp_ff)
            |-> wen_ff && we1n_ff && $stable(addr_ff) && $stable(wdata_ff);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write hold disturbed");

endmodule : smsc_strobe_ctrl

// ===== smsc_pkg.sv
// Shared constants and types of the static memory strobe engine
package smsc_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W    = 24;
    localparam int DATA_W    = 16;
    localparam int NUM_CS_MAX = 4;

    // ------------------------------------------------------------
    // Timing field widths, effective master clock cycle counts
    // ------------------------------------------------------------
    localparam int SETUP_W = 8;
    localparam int PULSE_W = 9;
    localparam int CYCLE_W = 10;
    localparam int SUM_W   = CYCLE_W + 1;

    // ------------------------------------------------------------
    // Flash latch enable positions on the address bus
    // ------------------------------------------------------------
    localparam int ALE_BIT = 21;
    localparam int CLE_BIT = 22;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic                  STROBE_IDLE = 1'b1;
    localparam logic [ADDR_W-1:0]     ADDR_RESET  = 24'h000000;
    localparam logic [DATA_W-1:0]     DATA_RESET  = 16'h0000;
    localparam logic [CYCLE_W-1:0]    CYC_RESET   = 10'h000;

    // ------------------------------------------------------------
    // Access engine states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMSC_IDLE   = 2'b01,
        SMSC_ACCESS = 2'b10
    } smsc_state_t;

endpackage : smsc_pkg

// ===== smsc_mem_model.sv
// Asynchronous memory model that answers reads on the data bus
module smsc_mem_model (
    // Memory pins
    input  wire logic        clk_in,
    input  wire logic [3:0]  cs_n_in,
    input  wire logic        oe_n_in,
    input  wire logic [23:0] addr_in,
    output logic      [15:0] data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] junk_ff = 16'h0f0f;
    // -----------------------------------------
    // Read answer
    // -----------------------------------------
    // Released bus toggles so a late capture never sees the word
    always_ff @(posedge clk_in) begin
        junk_ff <= ~junk_ff;
    end
    // stimulus keeps pulses legal, CE left to pins
    always_comb begin
        data_out = (!(&cs_n_in) && oe_n_in) ? (addr_in[15:0] ^ 16'h5a5a) : junk_ff;
    end
endmodule : smsc_mem_model

// ===== test_smsc_strobe_ctrl.sv
// Self-checking bench of the static memory strobe engine
module test_smsc_strobe_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic w; logic [1:0] cs; logic [7:0] s; logic [8:0] p;
        logic [9:0] c; logic md; logic fl; logic [23:0] a;} smsc_row_t;
    logic clk_in = 0, reset_in = 1, vld = 0, wr = 0, md = 1, fl = 0;
    logic [1:0] cs = 0;
    logic [7:0] s = 1;
    logic [8:0] p = 1;
    logic [9:0] c = 3;
    logic [23:0] a = 0, ao;
    logic [15:0] wd = 0, din, rd, dout;
    logic rdy, rv, rsn, wsn, b1w, b0s, b1s, oen, foe, fwe, fce, ale, cle;
    logic [3:0] csn;
    int mismatches = 0, n_tests = 0, rl, fr, cl, ol, fo, vk, n, bl, fc;
    smsc_row_t rows[7] = '{'{0,0,1,1,3,1,0,24'h000010}, '{0,1,2,3,8,0,0,24'h000123},
        '{1,2,1,2,5,1,0,24'h000456}, '{1,0,2,1,4,0,0,24'h000789},
        '{0,3,1,2,4,1,1,24'h400abc}, '{1,3,0,1,2,1,1,24'h200def},
        '{0,2,1,1,3,1,1,24'h000321}};
    smsc_strobe_ctrl u_dut (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(vld),
        .req_ready_out(rdy), .req_write_in(wr), .req_cs_in(cs), .req_addr_in(a),
        .req_wdata_in(wd), .req_byte_en_in(2'h3), .rdata_out(rd), .rdata_valid_out(rv),
        .rd_strobe_setup_cnt_in({4{s}}), .rd_strobe_pulse_cnt_in({4{p}}),
        .cs_read_setup_cnt_in({4{8'h00}}), .cs_read_pulse_cnt_in({4{c[8:0]}}),
        .read_cycle_cnt_in({4{c}}), .wr_strobe_setup_cnt_in({4{s}}),
        .wr_strobe_pulse_cnt_in({4{p}}), .cs_write_setup_cnt_in({4{8'h00}}),
        .cs_write_pulse_cnt_in({4{c[8:0]}}), .write_cycle_cnt_in({4{c}}),
        .read_mode_in({4{md}}), .write_mode_in({4{md}}), .byte_write_mode_in(4'h0),
        .matrix_flash_cs_config_in(fl ? 4'h8 : 4'h0), .addr_out(ao),
        .chip_select_n_out(csn), .read_strobe_n_out(rsn), .write_strobe_n_out(wsn),
        .byte1_write_strobe_n_out(b1w), .byte0_select_n_out(b0s),
        .byte1_select_n_out(b1s), .data_out(dout), .data_oe_n_out(oen), .data_in(din),
        .flash_output_enable_n_out(foe), .flash_write_enable_n_out(fwe),
        .flash_chip_enable_n_out(fce), .flash_ale_out(ale), .flash_cle_out(cle));
    smsc_mem_model u_mem (.clk_in(clk_in), .cs_n_in(csn), .oe_n_in(oen),
        .addr_in(ao), .data_out(din));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    // -----------------------------------------
    // Shared tasks
    // -----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic run(input smsc_row_t r);
        {rl, cl, ol, fo, n, fr, vk} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, -32'd1, -32'd1};
        {bl, fc} = 64'd0;
        @(negedge clk_in);
        {wr, cs, s, p, c, md, fl, a} = {r.w, r.cs, r.s, r.p, r.c, r.md, r.fl, r.a};
        wd = r.a[15:0] ^ 16'h1234;
        vld = 1'b1;
        while (rdy !== 1'b1 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        // Bounded wait: a stuck engine ends the run
        if (n >= 50) begin
            mismatches++;
            complete_run();
        end
        @(negedge clk_in);
        vld = 1'b0;
        // Sample before stepping: index k is the engine's own cycle k
        for (int k = 0; k <= int'(c); k++) begin
            if ((wr ? wsn : rsn) === 1'b0) begin
                rl++;
                fr = (fr < 0) ? k : fr;
            end
            cl += int'(csn[cs] === 1'b0);
            ol += int'(oen === 1'b0);
            fo += int'((wr ? fwe : foe) === 1'b0);
            bl += int'(b0s === 1'b0) + int'(b1s === 1'b0);
            fc += int'(fce === 1'b0);
            if (rv === 1'b1) begin
                vk = k;
                check(rd, a[15:0] ^ 16'h5a5a);
            end
            @(negedge clk_in);
        end
        check(bl, 2 * c);
        check(fc, (fl && cs == 2'h3) ? c : 0);
        check(rl, p);
        check(fr, s);
        check(cl, c);
        check(ol, wr ? (md ? c - s : c) : 0);
        check(vk, wr ? -1 : (md ? s + p : c));
        check(fo, (fl && cs == 2'h3) ? p : 0);
        check({cle, ale, ao}, {a[22:21], a});
        check(dout, wd);
    endtask : run
    // -----------------------------------------
    // Main sequence
    // -----------------------------------------
    initial begin
        repeat (20) @(negedge clk_in);
        check({rdy, csn, rsn, wsn, b1w, b0s, b1s, oen, foe, fwe, fce}, 14'h3fff);
        reset_in = 1'b0;
        foreach (rows[i]) run(rows[i]);
        // Back-to-back reads with no setup or hold keep strobes low
        @(negedge clk_in);
        {wr, cs, s, p, c, md, fl, rl, cl} = {1'b0, 2'h0, 8'h00, 9'h002, 10'h002, 2'b10, 64'd0};
        vld = 1'b1;
        for (int k = -1; k <= 3; k++) begin
            @(negedge clk_in);
            vld = (k >= 2) ? 1'b0 : vld;
            rl += int'(rsn === 1'b0);
            cl += int'(csn[0] === 1'b0);
        end
        check({rl, cl}, {32'd4, 32'd4});
        // Reset in mid write drops every strobe at once
        @(negedge clk_in);
        {wr, cs, vld} = {1'b1, 2'h3, 1'b1};
        @(negedge clk_in);
        check(wsn, 1'b0);
        {vld, reset_in} = 2'b01;
        @(negedge clk_in);
        check({rdy, csn, rsn, wsn, b1w, b0s, b1s, oen, foe, fwe, fce}, 14'h3fff);
        check({rv, rd}, 17'h00000);
        check(ao, 24'h000000);
        check(dout, 16'h0000);
        reset_in = 1'b0;
        run(rows[0]);
        repeat (3) @(negedge clk_in);
        complete_run();
    end
endmodule : test_smsc_strobe_ctrl
